// ### iid_consts.svh
// register offsets, field positions and reset values of the input interrupt detector
`ifndef IID_CONSTS_SVH
`define IID_CONSTS_SVH

`define IID_NSLOT 8
`define IID_AW 16
`define IID_CW 32

`define IID_OFF_CMD 12'h000
`define IID_OFF_CFG_LVL 12'h004
`define IID_OFF_CFG_SRC 12'h008
`define IID_OFF_ECOUNT 12'h00c
`define IID_OFF_STATE 12'h010
`define IID_OFF_ISTAT 12'h014
`define IID_OFF_IMASK 12'h018

`define IID_CMD_SLOT_MSB 2
`define IID_CMD_SLOT_LSB 0
`define IID_CMD_REG_BIT 3
`define IID_CMD_UNREG_BIT 4
`define IID_CMD_OVW_BIT 5
`define IID_CMD_ANALOG_BIT 6

`define IID_LVL_THR_MSB 15
`define IID_LVL_THR_LSB 0
`define IID_LVL_HYST_MSB 31
`define IID_LVL_HYST_LSB 16

`define IID_SRC_CHAN_MSB 2
`define IID_SRC_CHAN_LSB 0
`define IID_SRC_DIR_BIT 4
`define IID_SRC_EDGE_MSB 9
`define IID_SRC_EDGE_LSB 8

`define IID_STATE_REFUSED_BIT 16
`define IID_ISTAT_REFUSED_BIT 8

`define IID_HYST_DEF 16'h0014
`define IID_HYST_MAX 16'h03e8
`define IID_THR_DEF 16'h0000
`define IID_ECOUNT_DEF 32'h00000001

`endif

// ### iid_pkg.sv
// types shared by the input interrupt detector
package iid_pkg;
	typedef enum logic [1:0] {
		IID_EDGE_FALL = 2'h0,
		IID_EDGE_RISE = 2'h1,
		IID_EDGE_BOTH = 2'h2
	} iid_edge_t;

	typedef enum logic {
		IID_DIR_FALL = 1'b0,
		IID_DIR_RISE = 1'b1
	} iid_adir_t;

	typedef enum logic [1:0] {
		IID_ARM_IDLE = 2'b01,
		IID_ARM_READY = 2'b10
	} iid_arm_t;
endpackage : iid_pkg

// ### iid_slot.sv
// one interrupt slot: analog threshold crossing or digital edge counting
`timescale 1ns/1ps
`include "iid_consts.svh"
module iid_slot #(
	parameter int NCH = 8,
	parameter int AW = 16,
	parameter int CW = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load,
	input wire logic release_slot,
	input wire logic en,
	input wire logic cfg_analog,
	input wire iid_pkg::iid_adir_t cfg_dir,
	input wire iid_pkg::iid_edge_t cfg_edge,
	input wire logic [$clog2(NCH)-1:0] cfg_chan,
	input wire logic [AW-1:0] cfg_thr,
	input wire logic [AW-1:0] cfg_hyst,
	input wire logic [CW-1:0] cfg_count,
	input wire logic [NCH*AW-1:0] ain_bus,
	input wire logic ain_valid,
	input wire logic [NCH-1:0] din_bus,
	output logic fire
);
	logic analog;
	iid_pkg::iid_adir_t dir;
	iid_pkg::iid_edge_t edge_sel;
	logic [$clog2(NCH)-1:0] chan;
	logic [AW-1:0] thr;
	logic [AW-1:0] hyst;
	logic [CW-1:0] target;
	logic [CW-1:0] cnt;
	logic din_prev;
	iid_pkg::iid_arm_t arm;
	iid_pkg::iid_arm_t next_arm;
	logic qual;
	logic ana_hit;

	wire din_now = din_bus[chan];
	wire [AW-1:0] ain_now = ain_bus[chan*AW +: AW];
	wire rise = din_now & ~din_prev;
	wire fall = ~din_now & din_prev;
	// 17-bit sums so a large hysteresis never wraps
	wire above_hi = {1'b0, ain_now} > ({1'b0, thr} + {1'b0, hyst});
	wire below_lo = ({1'b0, ain_now} + {1'b0, hyst}) < {1'b0, thr};
	wire cross_fall = ain_now < thr;
	wire cross_rise = ain_now > thr;
	wire arm_cond = (dir == iid_pkg::IID_DIR_FALL) ? above_hi : below_lo; // [RULE6]
	wire hit_cond = (dir == iid_pkg::IID_DIR_FALL) ? cross_fall : cross_rise; // [RULE4]
	wire [CW-1:0] cnt_inc = cnt + {{(CW-1){1'b0}}, 1'b1};
	wire dig_hit = !analog && qual && (cnt_inc >= target); // [RULE8]

	always_comb begin
		unique case (edge_sel)
			iid_pkg::IID_EDGE_FALL: qual = fall; // [RULE7]
			iid_pkg::IID_EDGE_RISE: qual = rise; // [RULE7]
			iid_pkg::IID_EDGE_BOTH: qual = rise | fall; // [RULE7]
			default: qual = 1'b0;
		endcase
	end

	always_comb begin
		next_arm = arm;
		ana_hit = 1'b0;
		unique case (arm)
			iid_pkg::IID_ARM_IDLE: if (analog && ain_valid && arm_cond) begin
				next_arm = iid_pkg::IID_ARM_READY; // [RULE6]
			end
			iid_pkg::IID_ARM_READY: if (ain_valid && hit_cond) begin
				next_arm = iid_pkg::IID_ARM_IDLE;
				ana_hit = analog; // [RULE5]
			end
			default: next_arm = iid_pkg::IID_ARM_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analog <= 1'b0;
			dir <= iid_pkg::IID_DIR_FALL;
			edge_sel <= iid_pkg::IID_EDGE_FALL;
			chan <= '0;
			thr <= `IID_THR_DEF;
			hyst <= `IID_HYST_DEF;
			target <= `IID_ECOUNT_DEF;
		end else if (load) begin
			analog <= cfg_analog;
			dir <= cfg_dir;
			edge_sel <= cfg_edge;
			chan <= cfg_chan;
			thr <= cfg_thr;
			hyst <= cfg_hyst;
			target <= cfg_count;
		end
	end

	// a fresh load or release restarts counting and disarms the comparator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
			arm <= iid_pkg::IID_ARM_IDLE;
			din_prev <= 1'b0;
			fire <= 1'b0;
		end else if (load || release_slot) begin
			cnt <= '0;
			arm <= iid_pkg::IID_ARM_IDLE;
			din_prev <= din_bus[cfg_chan];
			fire <= 1'b0;
		end else begin
			cnt <= dig_hit ? '0 : (qual && !analog) ? cnt_inc : cnt;
			arm <= next_arm;
			din_prev <= din_now;
			fire <= en && (ana_hit || dig_hit); // [RULE9]
		end
	end

	AST_FIRE_NEEDS_EN: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
		fire |-> $past(en) && !$past(load) && !$past(release_slot))
		else $error("slot fired while not enabled");
	AST_ANA_DIR: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
		fire && analog |-> $past(hit_cond) && $past(ain_valid))
		else $error("analog fire without crossing in chosen direction");
	AST_ANA_ARMED: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
		fire && analog |-> $past(arm) == iid_pkg::IID_ARM_READY)
		else $error("analog fire without hysteresis arming");
	AST_ARM_HYST: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
		$rose(arm == iid_pkg::IID_ARM_READY) |-> $past(arm_cond) && $past(ain_valid))
		else $error("armed inside hysteresis window");
	AST_DIG_COUNT: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
		fire && !analog |-> $past(qual) && $past(cnt_inc) >= $past(target) && cnt == '0)
		else $error("digital fire before edge count reached");
	COV_ANA_FIRE: cover property (@(posedge pclk) disable iff (!presetn) fire && analog);
	COV_DIG_FIRE: cover property (@(posedge pclk) disable iff (!presetn)
		fire && !analog && edge_sel == iid_pkg::IID_EDGE_BOTH);
endmodule : iid_slot

// ### iid_src_model.sv
// analog sample and digital line source that feeds the detector inputs
`timescale 1ns/1ps
module iid_src_model (
	input wire logic pclk,
	output logic [127:0] ain_code,
	output logic ain_valid,
	output logic [7:0] din
);
	logic [15:0] samp [8];

	initial begin
		ain_code = '0;
		ain_valid = 1'b0;
		din = '0;
		for (int i = 0; i < 8; i++) samp[i] = '0;
	end

	// the sample set is only valid with the strobe; scramble it afterwards
	task automatic put(input int ch, input logic [15:0] v);
		samp[ch] = v;
		@(posedge pclk);
		for (int i = 0; i < 8; i++) ain_code[i*16+:16] <= samp[i];
		ain_valid <= 1'b1;
		@(posedge pclk);
		ain_valid <= 1'b0;
		ain_code <= ~ain_code;
	endtask : put

	task automatic line(input int ch, input logic v);
		@(posedge pclk);
		din[ch] <= v;
	endtask : line
endmodule : iid_src_model

// ### iid_top.sv
// apb register file and slot bookkeeping of the input interrupt detector
// How it works
// RULE1: eight slots numbered 0 to 7; a zero slot field selects slot 0.
// RULE2: registering an occupied slot is refused; after unregistering it is accepted again.
// RULE3: the overwrite bit lets an occupied slot be registered again.
// RULE4: analog direction 0 fires on falling crossing, 1 on rising crossing.
// RULE5: analog slot fires only when the sample crosses the threshold that way.
// RULE6: hysteresis window around the threshold, default 20 mV, clamped to 0..1000 mV.
// RULE7: edge code 0 falling, 1 rising, 2 both edges.
// RULE8: digital slot counts qualifying edges and fires when the count is reached.
// RULE9: unregistering stops further firing from that slot and frees it.
// RULE10: software opens the input channel before registering an interrupt on it.
// RULE11: inputs are synchronised first; each trigger sets one pending flag.
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "iid_consts.svh"
module iid_top #(
	parameter int NSLOT = `IID_NSLOT,
	parameter int NCH = 8,
	parameter int AW = `IID_AW,
	parameter int CW = `IID_CW
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NCH*AW-1:0] ain_code,
	input wire logic ain_valid,
	input wire logic [NCH-1:0] din,
	output logic irq
);
	logic [AW-1:0] thr_stage;
	logic [AW-1:0] hyst_stage;
	logic [$clog2(NCH)-1:0] chan_stage;
	iid_pkg::iid_adir_t dir_stage;
	iid_pkg::iid_edge_t edge_stage;
	logic [CW-1:0] count_stage;
	logic [NSLOT-1:0] occupied;
	logic [NSLOT-1:0] analog_kind;
	logic refused;
	logic [NSLOT:0] istat;
	logic [NSLOT:0] imask;
	logic [NCH-1:0] din_meta;
	logic [NCH-1:0] din_sync;
	logic [NCH*AW-1:0] ain_hold;
	logic ain_hold_valid;
	logic [NSLOT-1:0] fire;

	// bus decode
	wire wr = psel && penable && pwrite;
	wire rd_setup = psel && !penable && !pwrite;
	wire sel_cmd = paddr == `IID_OFF_CMD;
	wire sel_lvl = paddr == `IID_OFF_CFG_LVL;
	wire sel_src = paddr == `IID_OFF_CFG_SRC;
	wire sel_ecnt = paddr == `IID_OFF_ECOUNT;
	wire sel_state = paddr == `IID_OFF_STATE;
	wire sel_istat = paddr == `IID_OFF_ISTAT;
	wire sel_imask = paddr == `IID_OFF_IMASK;
	wire addr_hit = sel_cmd | sel_lvl | sel_src | sel_ecnt | sel_state | sel_istat | sel_imask;

	// command decode
	wire [2:0] cmd_slot = pwdata[`IID_CMD_SLOT_MSB:`IID_CMD_SLOT_LSB]; // [RULE1]
	wire [NSLOT-1:0] slot_oh = {{(NSLOT-1){1'b0}}, 1'b1} << cmd_slot; // [RULE1]
	wire do_reg = wr && sel_cmd && pwdata[`IID_CMD_REG_BIT];
	// register wins when both operation bits are set
	wire do_unreg = wr && sel_cmd && pwdata[`IID_CMD_UNREG_BIT] && !pwdata[`IID_CMD_REG_BIT];
	wire busy = occupied[cmd_slot];
	wire ovw = pwdata[`IID_CMD_OVW_BIT];
	wire reg_ok = do_reg && (!busy || ovw); // [RULE2] [RULE3]
	wire reg_refused = do_reg && busy && !ovw; // [RULE2]
	wire [NSLOT-1:0] load_vec = reg_ok ? slot_oh : '0;
	wire [NSLOT-1:0] free_vec = do_unreg ? slot_oh : '0; // [RULE9]
	wire [NSLOT-1:0] next_occupied = (occupied | load_vec) & ~free_vec;
	wire [NSLOT-1:0] next_kind = pwdata[`IID_CMD_ANALOG_BIT] ? (analog_kind | load_vec)
		: (analog_kind & ~load_vec);

	// hysteresis above the limit is clamped rather than rejected
	wire [AW-1:0] hyst_wr = pwdata[`IID_LVL_HYST_MSB:`IID_LVL_HYST_LSB];
	wire [AW-1:0] hyst_clamp = (hyst_wr > `IID_HYST_MAX) ? `IID_HYST_MAX : hyst_wr; // [RULE6]

	// interrupt status: set wins over write-one-to-clear
	wire [NSLOT:0] events = {reg_refused, fire}; // [RULE11]
	wire [NSLOT:0] w1c = (wr && sel_istat) ? pwdata[NSLOT:0] : '0;
	wire [NSLOT:0] next_istat = (istat & ~w1c) | events; // [RULE11]

	wire [31:0] state_word = {15'h0000, refused, analog_kind, occupied};
	wire [31:0] lvl_word = {hyst_stage, thr_stage};
	wire [31:0] src_word = {22'h000000, edge_stage, 3'h0, dir_stage, 1'b0, chan_stage};
	wire [31:0] rd_mux = sel_lvl ? lvl_word
		: sel_src ? src_word
		: sel_ecnt ? count_stage
		: sel_state ? state_word
		: sel_istat ? {23'h000000, istat}
		: sel_imask ? {23'h000000, imask}
		: 32'h00000000;

	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_hit;
	assign irq = |(istat & imask);

	// two flops on the asynchronous digital lines
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			din_meta <= '0;
			din_sync <= '0;
		end else begin
			din_meta <= din; // [RULE11]
			din_sync <= din_meta; // [RULE11]
		end
	end

	// analog codes come from converter logic on pclk; one capture stage aligns them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ain_hold <= '0;
			ain_hold_valid <= 1'b0;
		end else begin
			ain_hold_valid <= ain_valid; // [RULE11]
			if (ain_valid) begin
				ain_hold <= ain_code;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd_setup) begin
			prdata <= rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thr_stage <= `IID_THR_DEF;
			hyst_stage <= `IID_HYST_DEF; // [RULE6]
		end else if (wr && sel_lvl) begin
			thr_stage <= pwdata[`IID_LVL_THR_MSB:`IID_LVL_THR_LSB];
			hyst_stage <= hyst_clamp;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_stage <= '0;
			dir_stage <= iid_pkg::IID_DIR_FALL; // [RULE4]
			edge_stage <= iid_pkg::IID_EDGE_FALL; // [RULE7]
		end else if (wr && sel_src) begin
			chan_stage <= pwdata[`IID_SRC_CHAN_MSB:`IID_SRC_CHAN_LSB];
			dir_stage <= iid_pkg::iid_adir_t'(pwdata[`IID_SRC_DIR_BIT]);
			edge_stage <= iid_pkg::iid_edge_t'(pwdata[`IID_SRC_EDGE_MSB:`IID_SRC_EDGE_LSB]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_stage <= `IID_ECOUNT_DEF;
		end else if (wr && sel_ecnt) begin
			count_stage <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			occupied <= '0;
			analog_kind <= '0;
			refused <= 1'b0;
		end else begin
			occupied <= next_occupied; // [RULE2] [RULE9]
			analog_kind <= next_kind;
			if (do_reg) begin
				refused <= reg_refused; // [RULE2]
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat <= '0;
			imask <= '0;
		end else begin
			istat <= next_istat;
			if (wr && sel_imask) begin
				imask <= pwdata[NSLOT:0];
			end
		end
	end

	// stage registers are shared; each slot copies them only at its own registration
	for (genvar i = 0; i < NSLOT; i++) begin : g_slot
		iid_slot #(
			.NCH(NCH),
			.AW(AW),
			.CW(CW)
		) u_slot (
			.pclk(pclk),
			.presetn(presetn),
			.load(load_vec[i]),
			.release_slot(free_vec[i]),
			.en(occupied[i]),
			.cfg_analog(pwdata[`IID_CMD_ANALOG_BIT]),
			.cfg_dir(dir_stage),
			.cfg_edge(edge_stage),
			.cfg_chan(chan_stage),
			.cfg_thr(thr_stage),
			.cfg_hyst(hyst_stage),
			.cfg_count(count_stage),
			.ain_bus(ain_hold),
			.ain_valid(ain_hold_valid),
			.din_bus(din_sync),
			.fire(fire[i])
		);
	end

	AST_SLOT_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
		wr && sel_cmd && pwdata[`IID_CMD_REG_BIT] && cmd_slot == 3'h0 && !occupied[0]
		|=> occupied[0])
		else $error("default slot 0 not registered");
	AST_REFUSE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
		do_reg && busy && !ovw |=> refused && istat[`IID_ISTAT_REFUSED_BIT]
		&& analog_kind == $past(analog_kind))
		else $error("occupied slot registration not refused");
	// a freed slot is simply a free one again, so any free slot must be accepted
	AST_REREG_FREE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
		do_reg && !busy |=> !refused && occupied[$past(cmd_slot)])
		else $error("free slot registration not accepted");
	AST_OVERWRITE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
		do_reg && busy && ovw |=> !refused && occupied[$past(cmd_slot)])
		else $error("overwrite registration refused");
	AST_HYST_CLAMP: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
		hyst_stage <= `IID_HYST_MAX)
		else $error("hysteresis outside limit");
	AST_UNREG_QUIET: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
		do_unreg ##1 !occupied[$past(cmd_slot)] |-> (fire & occupied) == fire)
		else $error("released slot still firing");
	// slot number pinned to the unregister cycle; a back-to-back setup may change pwdata
	AST_UNREG_FREE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
		do_unreg |=> !occupied[$past(cmd_slot)] ##1 !occupied[$past(cmd_slot, 2)])
		else $error("unregister did not free slot");
	AST_PENDING: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
		|fire |=> (istat[NSLOT-1:0] & $past(fire)) == $past(fire))
		else $error("trigger lost its pending flag");
	// the first flop is still in reset at the release edge, hence two cycles of grace
	AST_SYNC_DELAY: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
		din_sync == $past(din, 2) || !$past(presetn, 2))
		else $error("digital input not two flops late");
	COV_REFUSED: cover property (@(posedge pclk) disable iff (!presetn) reg_refused);
	COV_OVERWRITE: cover property (@(posedge pclk) disable iff (!presetn) do_reg && busy && ovw);
	COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule : iid_top

// ### test_io_input_interrupt_detector.sv
// self-checking bench of the input interrupt detector
`timescale 1ns/1ps
`include "iid_consts.svh"
module test_io_input_interrupt_detector;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ain_valid, last_err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [127:0] ain_code;
	logic [7:0] din;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;

	iid_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ain_code(ain_code), .ain_valid(ain_valid), .din(din), .irq(irq));
	iid_src_model src (.pclk(pclk), .ain_code(ain_code), .ain_valid(ain_valid), .din(din));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic conclude();
		$display("checks %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	// a hang ends the run here rather than stalling the simulator
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors = num_errors + 1;
			conclude();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp,
		input string what);
		apb(1'b0, a, 32'h0);
		chk(what, rd & m, exp);
	endtask : rdc

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask : idle

	task automatic t_reset();
		rdc(`IID_OFF_STATE, '1, 32'h0, "state");
		rdc(`IID_OFF_CFG_LVL, '1, {`IID_HYST_DEF, `IID_THR_DEF}, "lvl");
		rdc(`IID_OFF_CFG_SRC, '1, 32'h0, "src");
		rdc(`IID_OFF_ECOUNT, '1, `IID_ECOUNT_DEF, "count");
		rdc(`IID_OFF_IMASK, '1, 32'h0, "mask");
		rdc(`IID_OFF_CMD, '1, 32'h0, "cmd");
		rdc(12'h01c, '1, 32'h0, "unmapped");
		chk("slverr", {31'h0, last_err}, 32'h1);
		chk("irq", {31'h0, irq}, 32'h0);
	endtask : t_reset

	task automatic t_clamp();
		apb(1'b1, `IID_OFF_CFG_LVL, 32'h03e9_0064);
		rdc(`IID_OFF_CFG_LVL, '1, {`IID_HYST_MAX, 16'h0064}, "hyst clamp");
		apb(1'b1, `IID_OFF_CFG_LVL, 32'h03e8_0000);
		rdc(`IID_OFF_CFG_LVL, '1, 32'h03e8_0000, "hyst max");
	endtask : t_clamp

	task automatic t_slots();
		apb(1'b1, `IID_OFF_IMASK, 32'h100);
		apb(1'b1, `IID_OFF_CMD, 32'h08);
		rdc(`IID_OFF_STATE, 32'h100ff, 32'h1, "slot zero");
		apb(1'b1, `IID_OFF_CMD, 32'h0f);
		rdc(`IID_OFF_STATE, 32'h100ff, 32'h81, "slot seven");
		apb(1'b1, `IID_OFF_CMD, 32'h0f);
		rdc(`IID_OFF_STATE, 32'h10000, 32'h10000, "refused");
		chk("refuse irq", {31'h0, irq}, 32'h1);
		apb(1'b1, `IID_OFF_ISTAT, 32'h100);
		idle(2);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		apb(1'b1, `IID_OFF_CMD, 32'h2f);
		rdc(`IID_OFF_STATE, 32'h10080, 32'h80, "overwrite");
		apb(1'b1, `IID_OFF_CMD, 32'h17);
		rdc(`IID_OFF_STATE, 32'hff, 32'h1, "freed");
		apb(1'b1, `IID_OFF_CMD, 32'h0f);
		rdc(`IID_OFF_STATE, 32'h100ff, 32'h81, "reused");
		// both operation bits on slot 1 as analog: the registration must win
		apb(1'b1, `IID_OFF_CMD, 32'h59);
		rdc(`IID_OFF_STATE, 32'h1ffff, 32'h00283, "reg beats unreg");
		apb(1'b1, `IID_OFF_CMD, 32'h11);
		rdc(`IID_OFF_STATE, 32'hff, 32'h81, "slot one freed");
		apb(1'b1, `IID_OFF_CMD, 32'h17);
		apb(1'b1, `IID_OFF_CMD, 32'h10);
		rdc(`IID_OFF_STATE, 32'hff, 32'h0, "all free");
	endtask : t_slots

	// six toggles from low; the third qualifying edge fires and the count restarts;
	// edge code 3 qualifies no edge at all
	task automatic t_dig(input logic [1:0] e, input int s);
		int q;
		logic lv;
		logic hit;
		q = 0;
		lv = 1'b0;
		apb(1'b1, `IID_OFF_IMASK, 32'h1 << s);
		apb(1'b1, `IID_OFF_CFG_SRC, {22'h0, e, 5'h0, 3'(s)}); // source set up first
		apb(1'b1, `IID_OFF_ECOUNT, 32'h3);
		apb(1'b1, `IID_OFF_CMD, 32'h08 | s);
		for (int i = 0; i < 6; i++) begin
			lv = ~lv;
			hit = 1'b0;
			src.line(s, lv);
			if (e == 2'h2 || (e != 2'h3 && lv == e[0])) begin
				q++;
				hit = (q % 3 == 0);
			end
			idle(8);
			rdc(`IID_OFF_ISTAT, 32'h1ff, {31'h0, hit} << s, "edge");
			if (hit) begin
				chk("edge irq", {31'h0, irq}, 32'h1);
				apb(1'b1, `IID_OFF_ISTAT, 32'h1 << s);
			end
		end
		apb(1'b1, `IID_OFF_CMD, 32'h10 | s);
		for (int i = 0; i < 6; i++) begin
			lv = ~lv;
			src.line(s, lv);
			idle(4);
		end
		idle(8);
		rdc(`IID_OFF_ISTAT, 32'h1ff, 32'h0, "after release");
		chk("irq idle", {31'h0, irq}, 32'h0);
	endtask : t_dig

	// threshold 1000 mV, window 20 mV; steps 2 and 7 of each table fire
	task automatic t_ana(input logic dir, input int s, input logic [15:0] v [8]);
		logic [7:0] exp;
		exp = 8'h84;
		apb(1'b1, `IID_OFF_IMASK, 32'h1 << s);
		apb(1'b1, `IID_OFF_CFG_LVL, 32'h0014_03e8);
		apb(1'b1, `IID_OFF_CFG_SRC, {27'h0, dir, 1'b0, 3'(s)});
		apb(1'b1, `IID_OFF_CMD, 32'h48 | s);
		for (int i = 0; i < 8; i++) begin
			src.put(s, v[i]);
			idle(4);
			rdc(`IID_OFF_ISTAT, 32'h1ff, {31'h0, exp[i]} << s, "analog");
			apb(1'b1, `IID_OFF_ISTAT, 32'h1ff);
		end
		apb(1'b1, `IID_OFF_CMD, 32'h10 | s);
	endtask : t_ana

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		rd = '0;
		last_err = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_clamp();
		t_slots();
		for (int e = 0; e < 4; e++) t_dig(2'(e), e);
		t_ana(1'b0, 3, '{16'd990, 16'd1030, 16'd999, 16'd1020, 16'd990, 16'd1021, 16'd1000,
			16'd999});
		t_ana(1'b1, 4, '{16'd1010, 16'd979, 16'd1001, 16'd980, 16'd1010, 16'd979, 16'd1000,
			16'd1001});
		conclude();
	end
endmodule : test_io_input_interrupt_detector
